// [design/tccc_pkg.sv]
// Overview of operation
// - capture edge sets channel event flag
// - counter match sets event flag in compare
// - flag clears by read-then-write-zero, event wins
// - writing one leaves flag; reset clears
// - irq enable gates flag onto request
// - buffered bit disables channel 1, frees pin
// - mode bit picks capture or compare
// - edge field zero: mode bit sets level
// - edge codes pick rising, falling, either
// - compare action: none, toggle, low, high
// - buffered mode ignores mode bit A
// - edge field zero returns pin to port
// - toggle on overflow in compare only
// - overflow action beats simultaneous compare
// - full duty force from next period
// - full duty level follows polarity
// - value register holds capture or compare
// - high byte read blocks captures until low
// - high byte write blocks compares until low
// - overflow at modulo drives toggle, duty
// - counter halt inhibits captures
package tccc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CH0_SC = 8'h25;
  localparam logic [7:0] ADDR_CH0_HI = 8'h26;
  localparam logic [7:0] ADDR_CH0_LO = 8'h27;
  localparam logic [7:0] ADDR_CH1_SC = 8'h28;
  localparam logic [7:0] ADDR_CH1_HI = 8'h29;
  localparam logic [7:0] ADDR_CH1_LO = 8'h2A;
  localparam int BIT_FLAG = 7;
  localparam int BIT_IE   = 6;
  localparam int BIT_MSB  = 5;
  localparam int BIT_MSA  = 4;
  localparam int BIT_ELSB = 3;
  localparam int BIT_ELSA = 2;
  localparam int BIT_TOV  = 1;
  localparam int BIT_MAX  = 0;
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_TOG  = 2'h1;
  localparam logic [1:0] ELS_CLR  = 2'h2;
  localparam logic [1:0] ELS_SET  = 2'h3;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] CH1_SC_MASK = 8'hDF;
endpackage : tccc_pkg

// [design/tccc_top.sv]
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tccc_top (
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  // register port
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  // shared counter
  input  wire logic [15:0] COUNT_IN,
  input  wire logic        OVERFLOW_IN,
  input  wire logic        COUNTER_HALT_IN,
  // pins
  input  wire logic [1:0]  CHANNEL_PIN_IN,
  output logic      [1:0]  CHANNEL_PIN_OUT,
  output logic      [1:0]  CHANNEL_PIN_OE_OUT,
  output logic      [1:0]  PIN_OWNED_OUT,
  // interrupt requests
  output logic      [1:0]  IRQ_OUT
);

  typedef struct packed {
    logic [1:0][7:0]  sc;
    logic [1:0][15:0] val;
    logic [15:0]      buf0;      // shadow of active buffered compare
    logic [1:0][7:0]  hi_buf;    // pending high bytes for writes
    logic [1:0]       flag_seen;
    logic [1:0]       cap_lock;
    logic [1:0]       cmp_lock;
    logic [1:0]       pin;
    logic [1:0]       max_act;
    logic [1:0][1:0]  sync1;
    logic [1:0][1:0]  sync2;
    logic [1:0]       pin_d;
    logic [7:0]       rdata;
  } tccc_state_s;

  tccc_state_s st_r, st_nxt;

  function automatic logic [1:0] ch_of(input logic [7:0] a);
    if (a == tccc_pkg::ADDR_CH0_SC || a == tccc_pkg::ADDR_CH0_HI
        || a == tccc_pkg::ADDR_CH0_LO) begin
      return 2'h1;
    end else if (a == tccc_pkg::ADDR_CH1_SC || a == tccc_pkg::ADDR_CH1_HI
        || a == tccc_pkg::ADDR_CH1_LO) begin
      return 2'h2;
    end else begin
      return 2'h0;
    end
  endfunction

  logic       buffered;
  logic [1:0] els   [2];
  logic [1:0] cap_m;
  logic [1:0] cmp_m;
  logic [1:0] rise, fall, cap_ev, cmp_ev;

  assign buffered = st_r.sc[0][tccc_pkg::BIT_MSB];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      els[i]   = st_r.sc[i][tccc_pkg::BIT_ELSB:tccc_pkg::BIT_ELSA];
      cap_m[i] = els[i] != tccc_pkg::ELS_OFF && !st_r.sc[i][tccc_pkg::BIT_MSA]
                 && !(i == 0 && buffered);
      cmp_m[i] = (i == 0 && buffered) ? els[0] != tccc_pkg::ELS_OFF
                 : st_r.sc[i][tccc_pkg::BIT_MSA];
      if (i == 1 && buffered) begin
        cap_m[i] = 1'b0;
        cmp_m[i] = 1'b0;
      end
      rise[i]  = st_r.sync2[i][0] & ~st_r.pin_d[i];
      fall[i]  = ~st_r.sync2[i][0] & st_r.pin_d[i];
      case (els[i])
        tccc_pkg::ELS_TOG: cap_ev[i] = rise[i];
        tccc_pkg::ELS_CLR: cap_ev[i] = fall[i];
        default:           cap_ev[i] = rise[i] | fall[i];
      endcase
      cap_ev[i] = cap_ev[i] & cap_m[i] & !COUNTER_HALT_IN;
      cmp_ev[i] = cmp_m[i] && !st_r.cmp_lock[i]
                  && COUNT_IN == ((i == 0 && buffered) ? st_r.buf0 : st_r.val[i]);
    end
  end

  always_comb begin
    logic [1:0] ch;
    logic       idx;
    logic       pol;
    ch  = ch_of(ADDR_IN);
    idx = ch[1];
    pol = 1'b0;
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    for (int i = 0; i < 2; i++) begin
      // two flops ahead of the edge detector: pins are asynchronous
      st_nxt.sync1[i] = {1'b0, CHANNEL_PIN_IN[i]};
      st_nxt.sync2[i] = st_r.sync1[i];
      st_nxt.pin_d[i] = st_r.sync2[i][0];
    end
    if (RD_IN && ch != 2'h0) begin
      if (ADDR_IN == tccc_pkg::ADDR_CH0_SC || ADDR_IN == tccc_pkg::ADDR_CH1_SC) begin
        st_nxt.rdata = st_r.sc[idx];
        st_nxt.flag_seen[idx] = st_r.sc[idx][tccc_pkg::BIT_FLAG];
      end else if (ADDR_IN == tccc_pkg::ADDR_CH0_HI || ADDR_IN == tccc_pkg::ADDR_CH1_HI) begin
        st_nxt.rdata = st_r.val[idx][15:8];
        if (cap_m[idx]) st_nxt.cap_lock[idx] = 1'b1;
      end else begin
        st_nxt.rdata = st_r.val[idx][7:0];
        st_nxt.cap_lock[idx] = 1'b0;
      end
    end
    if (WR_IN && ch != 2'h0) begin
      if (ADDR_IN == tccc_pkg::ADDR_CH0_SC || ADDR_IN == tccc_pkg::ADDR_CH1_SC) begin
        // ignore channel 1 control while buffered
        if (!(idx && buffered)) begin
          st_nxt.sc[idx][6:0] = WDATA_IN[6:0]
                                & (idx ? tccc_pkg::CH1_SC_MASK[6:0] : 7'h7F);
          if (!WDATA_IN[tccc_pkg::BIT_FLAG] && st_r.flag_seen[idx]) begin
            st_nxt.sc[idx][tccc_pkg::BIT_FLAG] = 1'b0;
          end
          st_nxt.flag_seen[idx] = 1'b0;
        end
      end else if (ADDR_IN == tccc_pkg::ADDR_CH0_HI || ADDR_IN == tccc_pkg::ADDR_CH1_HI) begin
        st_nxt.hi_buf[idx] = WDATA_IN;
        if (cmp_m[idx] || (idx && buffered)) st_nxt.cmp_lock[idx] = 1'b1;
      end else begin
        st_nxt.val[idx] = {st_r.hi_buf[idx], WDATA_IN};
        st_nxt.cmp_lock[idx] = 1'b0;
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (cap_ev[i] && !st_r.cap_lock[i]) st_nxt.val[i] = COUNT_IN;
      if (cap_ev[i] || cmp_ev[i]) begin
        st_nxt.sc[i][tccc_pkg::BIT_FLAG] = 1'b1;
        st_nxt.flag_seen[i] = 1'b0;
      end
      pol = els[i] == tccc_pkg::ELS_CLR;
      if (els[i] == tccc_pkg::ELS_OFF) begin
        st_nxt.pin[i] = ~st_r.sc[i][tccc_pkg::BIT_MSA];
      end else if (cmp_m[i]) begin
        if (OVERFLOW_IN && st_r.sc[i][tccc_pkg::BIT_TOV]) begin
          st_nxt.max_act[i] = st_r.sc[i][tccc_pkg::BIT_MAX];
          st_nxt.pin[i] = st_r.sc[i][tccc_pkg::BIT_MAX] ? pol : ~st_r.pin[i];
        end else if (st_r.max_act[i] && st_r.sc[i][tccc_pkg::BIT_TOV]) begin
          st_nxt.pin[i] = pol;
        end else if (cmp_ev[i]) begin
          case (els[i])
            tccc_pkg::ELS_TOG: st_nxt.pin[i] = ~st_r.pin[i];
            tccc_pkg::ELS_CLR: st_nxt.pin[i] = 1'b0;
            default:           st_nxt.pin[i] = 1'b1;
          endcase
        end
      end
    end
    // no swap while a channel 1 high byte is pending, else a torn value would load
    if (buffered && OVERFLOW_IN && !st_r.cmp_lock[1]) begin
      st_nxt.buf0 = st_r.val[1]; // alternate: ch1 value loads
      st_nxt.val[1] = st_r.val[0];
      st_nxt.val[0] = st_r.val[1];
    end
  end

  // value registers have no defined reset value, zero is as good as any
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      PIN_OWNED_OUT[k]      = els[k] != tccc_pkg::ELS_OFF && !(k == 1 && buffered);
      CHANNEL_PIN_OE_OUT[k] = PIN_OWNED_OUT[k] && cmp_m[k];
      IRQ_OUT[k] = st_r.sc[k][tccc_pkg::BIT_FLAG] & st_r.sc[k][tccc_pkg::BIT_IE];
    end
  end
  assign CHANNEL_PIN_OUT = st_r.pin;
  assign RDATA_OUT       = st_r.rdata;

  // flag and interrupt
  flag_stick_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cap_ev[0] || cmp_ev[0]) |=> st_r.sc[0][tccc_pkg::BIT_FLAG])
    else $error("event flag not set");

  flag_set1_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cap_ev[1] || cmp_ev[1])
    |=> st_r.sc[1][tccc_pkg::BIT_FLAG])
    else $error("channel 1 flag not set");

  flag_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == tccc_pkg::ADDR_CH0_SC && !WDATA_IN[tccc_pkg::BIT_FLAG]
     && st_r.flag_seen[0] && !cap_ev[0] && !cmp_ev[0]) |=> !st_r.sc[0][tccc_pkg::BIT_FLAG])
    else $error("flag not cleared after read and write zero");

  unseen_keep_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == tccc_pkg::ADDR_CH0_SC && !st_r.flag_seen[0]
     && st_r.sc[0][tccc_pkg::BIT_FLAG]) |=> st_r.sc[0][tccc_pkg::BIT_FLAG])
    else $error("flag cleared without prior read");

  irq_gate_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    IRQ_OUT[0] |-> st_r.sc[0][tccc_pkg::BIT_IE])
    else $error("irq without enable");

  irq_gate1_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    IRQ_OUT[1]
    |-> st_r.sc[1][tccc_pkg::BIT_IE])
    else $error("channel 1 irq without enable");

  irq_flag_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (st_r.sc[0][tccc_pkg::BIT_FLAG] && st_r.sc[0][tccc_pkg::BIT_IE])
    |-> IRQ_OUT[0])
    else $error("enabled flag without irq");

  halt_cap_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    COUNTER_HALT_IN |-> !cap_ev[0] && !cap_ev[1])
    else $error("capture while halted");

  write_one_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == tccc_pkg::ADDR_CH0_SC && WDATA_IN[7]
     && st_r.sc[0][7]) |=> st_r.sc[0][7])
    else $error("flag cleared by writing one");

  write_one1_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == tccc_pkg::ADDR_CH1_SC && WDATA_IN[tccc_pkg::BIT_FLAG]
     && st_r.sc[1][tccc_pkg::BIT_FLAG]) |=> st_r.sc[1][tccc_pkg::BIT_FLAG])
    else $error("channel 1 flag cleared by writing one");

  rd_lat_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (RD_IN && ADDR_IN == tccc_pkg::ADDR_CH0_SC) |=> RDATA_OUT == $past(st_r.sc[0]))
    else $error("read data wrong");

  rd_sc1_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (RD_IN && ADDR_IN == tccc_pkg::ADDR_CH1_SC)
    |=> RDATA_OUT == $past(st_r.sc[1]))
    else $error("channel 1 read data wrong");

  // mode decode and pin ownership
  ch1_off_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    buffered |-> !PIN_OWNED_OUT[1])
    else $error("channel 1 pin kept in buffered mode");

  ch1_quiet_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    buffered
    |-> !cap_ev[1] && !cmp_ev[1])
    else $error("channel 1 active in buffered mode");

  ch1_frozen_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (buffered && WR_IN && ADDR_IN == tccc_pkg::ADDR_CH1_SC)
    |=> st_r.sc[1] == $past(st_r.sc[1]))
    else $error("channel 1 control written in buffered mode");

  mode_pick_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (els[1] != tccc_pkg::ELS_OFF && !buffered)
    |-> cap_m[1] == !st_r.sc[1][tccc_pkg::BIT_MSA])
    else $error("mode bit does not pick capture");

  preset_lvl_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (els[1] == tccc_pkg::ELS_OFF)
    |=> CHANNEL_PIN_OUT[1] == !$past(st_r.sc[1][tccc_pkg::BIT_MSA]))
    else $error("preset level wrong");

  rise_only_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (els[0] == tccc_pkg::ELS_TOG && !rise[0])
    |-> !cap_ev[0])
    else $error("capture without rising edge");

  fall_only_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (els[0] == tccc_pkg::ELS_CLR && !fall[0])
    |-> !cap_ev[0])
    else $error("capture without falling edge");

  buf_mode_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    buffered
    |-> !cap_m[0] && (cmp_m[0] == (els[0] != tccc_pkg::ELS_OFF)))
    else $error("buffered mode decode wrong");

  port_free_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (els[0] == tccc_pkg::ELS_OFF)
    |-> !PIN_OWNED_OUT[0] && !CHANNEL_PIN_OE_OUT[0])
    else $error("pin kept with edge field zero");

  // compare actions on the pin
  cmp_high_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cmp_ev[1] && els[1] == tccc_pkg::ELS_SET && !st_r.sc[1][tccc_pkg::BIT_TOV])
    |=> CHANNEL_PIN_OUT[1])
    else $error("set action missed");

  cmp_low_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cmp_ev[1] && els[1] == tccc_pkg::ELS_CLR && !st_r.sc[1][tccc_pkg::BIT_TOV])
    |=> !CHANNEL_PIN_OUT[1])
    else $error("clear action missed");

  cmp_tog_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cmp_ev[1] && els[1] == tccc_pkg::ELS_TOG && !st_r.sc[1][tccc_pkg::BIT_TOV])
    |=> CHANNEL_PIN_OUT[1] != $past(CHANNEL_PIN_OUT[1]))
    else $error("toggle action missed");

  lock_cmp_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    st_r.cmp_lock[1] |-> !cmp_ev[1])
    else $error("compare while locked");

  lock_cmp0_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    st_r.cmp_lock[0]
    |-> !cmp_ev[0])
    else $error("channel 0 compare while locked");

  // overflow, full duty and buffering
  tov_tog_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cmp_m[0] && els[0] != tccc_pkg::ELS_OFF && OVERFLOW_IN && st_r.sc[0][tccc_pkg::BIT_TOV]
     && !st_r.sc[0][tccc_pkg::BIT_MAX]) |=> CHANNEL_PIN_OUT[0] != $past(CHANNEL_PIN_OUT[0]))
    else $error("no toggle on overflow");

  tov_capture_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    cap_m[0]
    |=> CHANNEL_PIN_OUT[0] == $past(CHANNEL_PIN_OUT[0]))
    else $error("pin moved in capture mode");

  ovf_first_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cmp_ev[1] && OVERFLOW_IN && st_r.sc[1][tccc_pkg::BIT_TOV] && !st_r.sc[1][tccc_pkg::BIT_MAX]
     && els[1] == tccc_pkg::ELS_SET) |=> CHANNEL_PIN_OUT[1] != $past(CHANNEL_PIN_OUT[1]))
    else $error("compare beat overflow");

  max_force_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cmp_m[1] && els[1] != tccc_pkg::ELS_OFF && OVERFLOW_IN && st_r.sc[1][tccc_pkg::BIT_TOV]
     && st_r.sc[1][tccc_pkg::BIT_MAX]) |=> CHANNEL_PIN_OUT[1]
     == ($past(st_r.sc[1][tccc_pkg::BIT_ELSB:tccc_pkg::BIT_ELSA]) == tccc_pkg::ELS_CLR))
    else $error("full duty level wrong at overflow");

  max_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cmp_m[1] && els[1] != tccc_pkg::ELS_OFF && !OVERFLOW_IN && st_r.max_act[1]
     && st_r.sc[1][tccc_pkg::BIT_TOV]) |=> CHANNEL_PIN_OUT[1]
     == ($past(st_r.sc[1][tccc_pkg::BIT_ELSB:tccc_pkg::BIT_ELSA]) == tccc_pkg::ELS_CLR))
    else $error("full duty level not held");

  swap_load_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (buffered && OVERFLOW_IN && !st_r.cmp_lock[1])
    |=> st_r.buf0 == $past(st_r.val[1]))
    else $error("buffered value not loaded");

  // value register interlocks
  cap_val_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cap_ev[0] && !st_r.cap_lock[0] && !WR_IN) |=> st_r.val[0] == $past(COUNT_IN))
    else $error("capture value wrong");

  cap_take_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (cap_ev[1] && !st_r.cap_lock[1] && !WR_IN)
    |=> st_r.val[1] == $past(COUNT_IN))
    else $error("channel 1 capture value wrong");

  cap_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (st_r.cap_lock[0] && !WR_IN && !buffered)
    |=> st_r.val[0] == $past(st_r.val[0]))
    else $error("capture while high byte read pending");

  val_commit_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == tccc_pkg::ADDR_CH1_LO && !cap_ev[1] && !(buffered && OVERFLOW_IN))
    |=> st_r.val[1] == {$past(st_r.hi_buf[1]), $past(WDATA_IN)})
    else $error("value write not committed");

  // scenario coverage
  cap_c: cover property (@(posedge CLOCK_IN) cap_ev[0]);
  cmp_c: cover property (@(posedge CLOCK_IN) cmp_ev[1]);
  buf_c: cover property (@(posedge CLOCK_IN) buffered && OVERFLOW_IN);
  ovf_tog_c: cover property (@(posedge CLOCK_IN)
    OVERFLOW_IN && cmp_m[1] && st_r.sc[1][tccc_pkg::BIT_TOV]);
  max_c: cover property (@(posedge CLOCK_IN)
    st_r.max_act[1] && st_r.sc[1][tccc_pkg::BIT_TOV]);
endmodule // tccc_top
`default_nettype wire

// [test/tccc_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
// far side of the channel pins: an outside driver that gives way while the timer drives
module tccc_pin_model (
  // outside drive and timer side
  input  wire logic [1:0] drive_in,
  input  wire logic [1:0] level_in,
  input  wire logic [1:0] oe_in,
  // resolved wire
  output logic      [1:0] pin_out
);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_out[i] = oe_in[i] ? level_in[i] : drive_in[i];
    end
  end
endmodule // tccc_pin_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d;
  logic        wr = 1'b0, rd = 1'b0, ovf = 1'b0, halt = 1'b0;
  logic [15:0] count = 16'h0000;
  logic [1:0]  ext = 2'h0, pin, pout, poe, owned, irq;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  always #50 clk = ~clk;
  tccc_top dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .COUNT_IN(count), .OVERFLOW_IN(ovf),
    .COUNTER_HALT_IN(halt), .CHANNEL_PIN_IN(pin), .CHANNEL_PIN_OUT(pout),
    .CHANNEL_PIN_OE_OUT(poe), .PIN_OWNED_OUT(owned), .IRQ_OUT(irq));
  tccc_pin_model pm (.drive_in(ext), .level_in(pout), .oe_in(poe), .pin_out(pin));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pin_step(input logic v);
    @(posedge clk); ext[0] <= v;
    repeat (5) @(posedge clk);
  endtask
  task automatic t_reset;
    rd_reg(tccc_pkg::ADDR_CH0_SC, d); `CHK(d, tccc_pkg::SC_RESET)
    rd_reg(tccc_pkg::ADDR_CH1_SC, d); `CHK(d, tccc_pkg::SC_RESET)
    rd_reg(8'h30, d); `CHK(d, 8'h00)
    `CHK(irq, 2'h0)
    `CHK(owned, 2'h0)
  endtask
  task automatic t_capture;
    halt <= 1'b1;
    wr_reg(tccc_pkg::ADDR_CH0_SC, 8'h44);
    rd_reg(tccc_pkg::ADDR_CH0_SC, d);
    wr_reg(tccc_pkg::ADDR_CH0_SC, 8'h44);
    pin_step(1'b1);
    rd_reg(tccc_pkg::ADDR_CH0_SC, d); `CHK(d, 8'h44)
    halt <= 1'b0;
    pin_step(1'b0);
    rd_reg(tccc_pkg::ADDR_CH0_SC, d); `CHK(d, 8'h44)
    count <= 16'h1234;
    pin_step(1'b1);
    rd_reg(tccc_pkg::ADDR_CH0_SC, d); `CHK(d, 8'hC4)
    `CHK(irq[0], 1'b1)
    rd_reg(tccc_pkg::ADDR_CH0_HI, d); `CHK(d, 8'h12)
    count <= 16'h5678;
    pin_step(1'b0);
    pin_step(1'b1);
    rd_reg(tccc_pkg::ADDR_CH0_LO, d); `CHK(d, 8'h34)
  endtask
  task automatic t_clear;
    wr_reg(tccc_pkg::ADDR_CH0_SC, 8'hC4);
    rd_reg(tccc_pkg::ADDR_CH0_SC, d); `CHK(d, 8'hC4)
    wr_reg(tccc_pkg::ADDR_CH0_SC, 8'h44);
    rd_reg(tccc_pkg::ADDR_CH0_SC, d); `CHK(d, 8'h44)
    `CHK(irq[0], 1'b0)
  endtask
  task automatic match(input logic [15:0] v);
    @(posedge clk); count <= v;
    @(posedge clk); count <= 16'hFFFF;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse_ovf;
    @(posedge clk); ovf <= 1'b1;
    @(posedge clk); ovf <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_compare;
    count <= 16'hFFFF;
    halt <= 1'b1;
    wr_reg(tccc_pkg::ADDR_CH1_SC, 8'h1C);
    wr_reg(tccc_pkg::ADDR_CH1_HI, 8'h00);
    wr_reg(tccc_pkg::ADDR_CH1_LO, 8'h20);
    halt <= 1'b0;
    match(16'h0020);
    rd_reg(tccc_pkg::ADDR_CH1_SC, d); `CHK(d, 8'h9C)
    `CHK({owned[1], poe[1], pout[1]}, 3'h7)
    wr_reg(tccc_pkg::ADDR_CH1_SC, 8'h1C);
    wr_reg(tccc_pkg::ADDR_CH1_HI, 8'h00);
    match(16'h0020);
    rd_reg(tccc_pkg::ADDR_CH1_SC, d); `CHK(d, 8'h1C)
    wr_reg(tccc_pkg::ADDR_CH1_LO, 8'h20);
  endtask
  task automatic t_toggle;
    wr_reg(tccc_pkg::ADDR_CH1_SC, 8'h1A);
    pulse_ovf();
    `CHK(pout[1], 1'b0)
    wr_reg(tccc_pkg::ADDR_CH1_SC, 8'h1B);
    pulse_ovf();
    `CHK(pout[1], 1'b1)
    match(16'h0020);
    #1 `CHK(pout[1], 1'b1)
  endtask
  task automatic t_buffer;
    wr_reg(tccc_pkg::ADDR_CH0_SC, 8'h24);
    #1 `CHK(owned[1], 1'b0)
    wr_reg(tccc_pkg::ADDR_CH1_SC, 8'h00);
    rd_reg(tccc_pkg::ADDR_CH1_SC, d); `CHK(d, 8'h9B)
    pulse_ovf();
    rd_reg(tccc_pkg::ADDR_CH0_LO, d); `CHK(d, 8'h20)
  endtask
  task automatic final_report;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ceiling well above the roughly 120 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_capture();
    t_clear();
    t_compare();
    t_toggle();
    t_buffer();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
